/* File: logic/lirb_pkg.sv */
// shared constants and types for the low i/o register bank
`default_nettype none
package lirb_pkg;

   // address space layout
   localparam logic [6:0] IO_TOP      = 7'h1f;
   localparam logic [6:0] DS_OFFSET   = 7'h20;
   localparam logic [6:0] DS_TOP      = 7'h3f;
   localparam int         NREG        = 32;
   localparam logic [7:0] RST_BYTE    = 8'h00;

   // register index within the bank
   localparam logic [4:0] A_PWR_RED   = 5'h00;
   localparam logic [4:0] A_AIN_DIS   = 5'h01;
   localparam logic [4:0] A_CONV_B    = 5'h03;
   localparam logic [4:0] A_RES_LOW   = 5'h04;
   localparam logic [4:0] A_RES_HIGH  = 5'h05;
   localparam logic [4:0] A_CONV_A    = 5'h06;
   localparam logic [4:0] A_CONV_MUX  = 5'h07;
   localparam logic [4:0] A_COMP      = 5'h08;
   localparam logic [4:0] A_T1_FLAGS  = 5'h0b;
   localparam logic [4:0] A_T1_MASK   = 5'h0c;
   localparam logic [4:0] A_USI_CTRL  = 5'h0d;
   localparam logic [4:0] A_USI_STAT  = 5'h0e;
   localparam logic [4:0] A_USI_DATA  = 5'h0f;
   localparam logic [4:0] A_USI_BUF   = 5'h10;
   localparam logic [4:0] A_PC_MASK   = 5'h12;
   localparam logic [4:0] A_SCRATCH0  = 5'h13;
   localparam logic [4:0] A_SCRATCH1  = 5'h14;
   localparam logic [4:0] A_SCRATCH2  = 5'h15;
   localparam logic [4:0] A_PORT_B_INPUT_PINS      = 5'h16;
   localparam logic [4:0] A_DIR_B     = 5'h17;
   localparam logic [4:0] A_OUT_B     = 5'h18;
   localparam logic [4:0] A_PORT_A_INPUT_PINS      = 5'h19;

   // field positions inside registers
   localparam int B_TOV1   = 0;
   localparam int B_OCF1A  = 1;
   localparam int B_OCF1B  = 2;
   localparam int B_ICF1   = 5;
   localparam int B_ACI    = 4;
   localparam int B_ACO    = 5;
   localparam int B_ADIF   = 4;
   localparam int B_USIDC  = 4;
   localparam int B_USIPF  = 5;
   localparam int B_USIOIF = 6;
   localparam int B_USISIF = 7;

   // sticky flag vector positions
   localparam int F_TOV1   = 0;
   localparam int F_OCF1A  = 1;
   localparam int F_OCF1B  = 2;
   localparam int F_ICF1   = 3;
   localparam int F_ACI    = 4;
   localparam int F_ADIF   = 5;
   localparam int F_USIPF  = 6;
   localparam int F_USIOIF = 7;
   localparam int F_USISIF = 8;
   localparam int NFLAG    = 9;

   // access kinds issued by the core
   typedef enum logic [2:0] {
      K_READ  = 3'b000,
      K_WRITE = 3'b001,
      K_SET   = 3'b010,
      K_CLEAR = 3'b011,
      K_TEST  = 3'b100
   } lirb_kind_t;

   typedef struct packed {
      logic       valid;
      lirb_kind_t kind;
      logic       data_space;
      logic [6:0] addr;
      logic [2:0] bit_sel;
      logic [7:0] wdata;
   } lirb_req_t;

   typedef struct packed {
      logic [7:0]       pin_a;
      logic [3:0]       pin_b;
      logic [7:0]       conv_low;
      logic [7:0]       conv_high;
      logic [7:0]       usi_buf;
      logic             comp_out;
      logic             usi_collision;
      logic [NFLAG-1:0] flag_set;
   } lirb_periph_in_t;

   typedef struct packed {
      logic [7:0]       power_red;
      logic [7:0]       ain_disable;
      logic [7:0]       conv_b;
      logic [7:0]       conv_a;
      logic [7:0]       conv_mux;
      logic [7:0]       comp_ctrl;
      logic [7:0]       t1_mask;
      logic [7:0]       usi_ctrl;
      logic [7:0]       usi_count;
      logic [7:0]       usi_data;
      logic [7:0]       pc_mask;
      logic [7:0]       dir_b;
      logic [7:0]       out_b;
      logic [NFLAG-1:0] flags;
   } lirb_ctrl_t;

   // bits that software may store per register; everything else is zero or live
   function automatic logic [7:0] rw_mask(input logic [4:0] idx);
      case (idx)
         A_PWR_RED:  rw_mask = 8'h0f;
         A_AIN_DIS:  rw_mask = 8'hff;
         A_CONV_B:   rw_mask = 8'hd7;
         A_CONV_A:   rw_mask = 8'hef;
         A_CONV_MUX: rw_mask = 8'hff;
         A_COMP:     rw_mask = 8'hcf;
         A_T1_MASK:  rw_mask = 8'h27;
         A_USI_CTRL: rw_mask = 8'hff;
         A_USI_STAT: rw_mask = 8'h0f;
         A_USI_DATA: rw_mask = 8'hff;
         A_PC_MASK:  rw_mask = 8'hff;
         A_SCRATCH0: rw_mask = 8'hff;
         A_SCRATCH1: rw_mask = 8'hff;
         A_SCRATCH2: rw_mask = 8'hff;
         A_DIR_B:    rw_mask = 8'h0f;
         A_OUT_B:    rw_mask = 8'h0f;
         default:    rw_mask = 8'h00;
      endcase
   endfunction : rw_mask

endpackage : lirb_pkg
`default_nettype wire

/* File: logic/lirb_decode.sv */
// address decode: i/o and data-space alias onto one bank index
`timescale 1ns/1ps
`default_nettype none
module lirb_decode (
   // request from the core
   input  wire lirb_pkg::lirb_req_t req,
   // decode results
   output logic [4:0]              io_idx,
   output logic                    in_bank,
   output logic                    bit_ok
);
   logic [6:0] io_addr;

   // data-space addresses sit 0x20 above the i/o address
   always_comb begin
      io_addr = req.data_space ? 7'(req.addr - lirb_pkg::DS_OFFSET) : req.addr;
      io_idx  = io_addr[4:0];
      if (req.data_space) begin
         in_bank = (req.addr >= lirb_pkg::DS_OFFSET) && (req.addr <= lirb_pkg::DS_TOP);
      end else begin
         in_bank = (req.addr <= lirb_pkg::IO_TOP);
      end
      // single-bit opcodes carry i/o addresses only
      bit_ok = in_bank && !req.data_space;
   end
endmodule : lirb_decode
`default_nettype wire

/* File: logic/lirb_flags.sv */
// sticky status flags, set by peripheral events, cleared by the core
`timescale 1ns/1ps
`default_nettype none
module lirb_flags (
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst_b,
   // events and clears
   input  wire logic [lirb_pkg::NFLAG-1:0] set_evt,
   input  wire logic [lirb_pkg::NFLAG-1:0] clr_req,
   // flag state
   output logic      [lirb_pkg::NFLAG-1:0] flags_r
);
   // one flop per flag; an event in the clearing cycle must not be lost
   for (genvar i = 0; i < lirb_pkg::NFLAG; i++) begin : g_flag
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            flags_r[i] <= 1'b0;
         end else if (set_evt[i]) begin
            flags_r[i] <= 1'b1;
         end else if (clr_req[i]) begin
            flags_r[i] <= 1'b0;
         end
      end
   end

   chk_set_beats_clear: assert property (@(posedge clk) disable iff (!rst_b)
      set_evt[0] && clr_req[0] |=> flags_r[0])
      else $error("flag cleared although an event arrived");
endmodule : lirb_flags
`default_nettype wire

/* File: logic/lirb_bank.sv */
// low i/o register bank: byte, single-bit and test access for the core
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - any register at i/o address 0x00 to 0x1F can have one chosen bit set or cleared by a bit opcode.
// - in that range the state of one chosen bit is returned to the skip-if-set and skip-if-clear tests.
// - certain status flags clear when a one is written to them and keep their value when a zero is written.
// - a bit set or clear touches only the addressed bit and never clears other flags of the register.
// - bit set and clear act only on i/o addresses 0x00 to 0x1F; higher registers take whole bytes only.
module lirb_bank (
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst_b,
   // core access
   input  wire lirb_pkg::lirb_req_t       req,
   output logic [7:0]                     rd_data_r,
   output logic                           rd_valid_r,
   output logic                           test_bit_r,
   output logic                           test_valid_r,
   // peripheral side
   input  wire lirb_pkg::lirb_periph_in_t per_in,
   output lirb_pkg::lirb_ctrl_t           ctrl
);
   logic [4:0]                 dec_idx;
   logic                       in_bank;
   logic                       bit_ok;
   logic [7:0]                 mem_r [0:lirb_pkg::NREG-1];
   logic [lirb_pkg::NFLAG-1:0] flags_r;
   logic [lirb_pkg::NFLAG-1:0] flag_clr;
   logic [7:0]                 cur_byte;
   logic [7:0]                 bit_mask;
   logic [7:0]                 new_byte;
   logic [7:0]                 w1c_src;
   logic                       is_rd;
   logic                       is_wr;
   logic                       is_set;
   logic                       is_clr;
   logic                       is_test;
   logic                       wen;

   lirb_decode u_decode (
      .req     (req),
      .io_idx  (dec_idx),
      .in_bank (in_bank),
      .bit_ok  (bit_ok)
   );

   lirb_flags u_flags (
      .clk     (clk),
      .rst_b   (rst_b),
      .set_evt (per_in.flag_set),
      .clr_req (flag_clr),
      .flags_r (flags_r)
   );

   // read view of one register: stored bits merged with live inputs and flags
   function automatic logic [7:0] read_byte(input logic [4:0] i);
      logic [7:0] v;
      v = mem_r[i];
      case (i)
         lirb_pkg::A_PORT_A_INPUT_PINS:     v = per_in.pin_a;
         lirb_pkg::A_PORT_B_INPUT_PINS:     v = {4'h0, per_in.pin_b};
         lirb_pkg::A_RES_LOW:  v = per_in.conv_low;
         lirb_pkg::A_RES_HIGH: v = per_in.conv_high;
         lirb_pkg::A_USI_BUF:  v = per_in.usi_buf;
         lirb_pkg::A_T1_FLAGS: begin
            v                   = 8'h00;
            v[lirb_pkg::B_TOV1]  = flags_r[lirb_pkg::F_TOV1];
            v[lirb_pkg::B_OCF1A] = flags_r[lirb_pkg::F_OCF1A];
            v[lirb_pkg::B_OCF1B] = flags_r[lirb_pkg::F_OCF1B];
            v[lirb_pkg::B_ICF1]  = flags_r[lirb_pkg::F_ICF1];
         end
         lirb_pkg::A_COMP: begin
            v[lirb_pkg::B_ACO] = per_in.comp_out;
            v[lirb_pkg::B_ACI] = flags_r[lirb_pkg::F_ACI];
         end
         lirb_pkg::A_CONV_A: begin
            v[lirb_pkg::B_ADIF] = flags_r[lirb_pkg::F_ADIF];
         end
         lirb_pkg::A_USI_STAT: begin
            v[lirb_pkg::B_USIDC]  = per_in.usi_collision;
            v[lirb_pkg::B_USIPF]  = flags_r[lirb_pkg::F_USIPF];
            v[lirb_pkg::B_USIOIF] = flags_r[lirb_pkg::F_USIOIF];
            v[lirb_pkg::B_USISIF] = flags_r[lirb_pkg::F_USISIF];
         end
         default: v = mem_r[i];
      endcase
      return v;
   endfunction : read_byte

   // request kind decode
   always_comb begin
      is_rd   = req.valid && (req.kind == lirb_pkg::K_READ);
      is_wr   = req.valid && (req.kind == lirb_pkg::K_WRITE);
      is_set  = req.valid && (req.kind == lirb_pkg::K_SET);
      is_clr  = req.valid && (req.kind == lirb_pkg::K_CLEAR);
      is_test = req.valid && (req.kind == lirb_pkg::K_TEST);
   end

   // write data: a bit opcode is a read-modify-write of the current view
   always_comb begin
      cur_byte = read_byte(dec_idx);
      bit_mask = 8'(8'h01 << req.bit_sel);
      new_byte = req.wdata;
      w1c_src  = req.wdata;
      wen      = (is_wr && in_bank) || ((is_set || is_clr) && bit_ok);
      if (is_set) begin
         new_byte = cur_byte | bit_mask;
         w1c_src  = bit_mask;
      end else if (is_clr) begin
         new_byte = cur_byte & ~bit_mask;
         w1c_src  = 8'h00;
      end
   end

   always_comb begin
      flag_clr = '0;
      if (wen) begin
         case (dec_idx)
            lirb_pkg::A_T1_FLAGS: begin
               flag_clr[lirb_pkg::F_TOV1]  = w1c_src[lirb_pkg::B_TOV1];
               flag_clr[lirb_pkg::F_OCF1A] = w1c_src[lirb_pkg::B_OCF1A];
               flag_clr[lirb_pkg::F_OCF1B] = w1c_src[lirb_pkg::B_OCF1B];
               flag_clr[lirb_pkg::F_ICF1]  = w1c_src[lirb_pkg::B_ICF1];
            end
            lirb_pkg::A_COMP:   flag_clr[lirb_pkg::F_ACI]  = w1c_src[lirb_pkg::B_ACI];
            lirb_pkg::A_CONV_A: flag_clr[lirb_pkg::F_ADIF] = w1c_src[lirb_pkg::B_ADIF];
            lirb_pkg::A_USI_STAT: begin
               flag_clr[lirb_pkg::F_USIPF]  = w1c_src[lirb_pkg::B_USIPF];
               flag_clr[lirb_pkg::F_USIOIF] = w1c_src[lirb_pkg::B_USIOIF];
               flag_clr[lirb_pkg::F_USISIF] = w1c_src[lirb_pkg::B_USISIF];
            end
            default: flag_clr = '0;
         endcase
      end
   end

   // storage per entry; the mask drops reserved, read-only and flag bits,
   // so stray writes to reserved addresses are harmless
   for (genvar i = 0; i < lirb_pkg::NREG; i++) begin : g_reg
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            mem_r[i] <= lirb_pkg::RST_BYTE;
         end else if (wen && (dec_idx == 5'(i))) begin
            mem_r[i] <= new_byte & lirb_pkg::rw_mask(5'(i));
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_r  <= 8'h00;
         rd_valid_r <= 1'b0;
      end else begin
         rd_valid_r <= is_rd;
         // addresses outside the bank read as zero
         rd_data_r  <= (is_rd && in_bank) ? cur_byte : 8'h00;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         test_bit_r   <= 1'b0;
         test_valid_r <= 1'b0;
      end else begin
         test_valid_r <= is_test && bit_ok;
         test_bit_r   <= (is_test && bit_ok) ? cur_byte[req.bit_sel] : 1'b0;
      end
   end

   // control fields to peripherals, straight from the storage flops
   assign ctrl.power_red   = mem_r[lirb_pkg::A_PWR_RED];
   assign ctrl.ain_disable = mem_r[lirb_pkg::A_AIN_DIS];
   assign ctrl.conv_b      = mem_r[lirb_pkg::A_CONV_B];
   assign ctrl.conv_a      = mem_r[lirb_pkg::A_CONV_A];
   assign ctrl.conv_mux    = mem_r[lirb_pkg::A_CONV_MUX];
   assign ctrl.comp_ctrl   = mem_r[lirb_pkg::A_COMP];
   assign ctrl.t1_mask     = mem_r[lirb_pkg::A_T1_MASK];
   assign ctrl.usi_ctrl    = mem_r[lirb_pkg::A_USI_CTRL];
   assign ctrl.usi_count   = mem_r[lirb_pkg::A_USI_STAT];
   assign ctrl.usi_data    = mem_r[lirb_pkg::A_USI_DATA];
   assign ctrl.pc_mask     = mem_r[lirb_pkg::A_PC_MASK];
   assign ctrl.dir_b       = mem_r[lirb_pkg::A_DIR_B];
   assign ctrl.out_b       = mem_r[lirb_pkg::A_OUT_B];
   assign ctrl.flags       = flags_r;

   // helper state for checks: previous request's target and bit, whatever its kind, and that target's view now
   logic [4:0] chk_idx_r;
   logic [2:0] chk_bit_r;
   logic [7:0] chk_view;
   logic [7:0] cur_mask;
   logic [7:0] raw_view;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         chk_idx_r <= 5'h00;
         chk_bit_r <= 3'h0;
      end else begin
         chk_idx_r <= dec_idx;
         chk_bit_r <= req.bit_sel;
      end
   end
   assign chk_view = read_byte(chk_idx_r);
   // storable bits at the target, and a view indexed by the raw low address bits,
   // so the alias check does not lean on the decoder's own subtraction
   assign cur_mask = lirb_pkg::rw_mask(dec_idx);
   assign raw_view = read_byte(req.addr[4:0]);

   chk_bit_set_lands: assert property (@(posedge clk) disable iff (!rst_b)
      is_set && bit_ok && cur_mask[req.bit_sel] |=> chk_view[chk_bit_r])
      else $error("bit set did not store a one");

   chk_bit_clr_lands: assert property (@(posedge clk) disable iff (!rst_b)
      is_clr && bit_ok && cur_mask[req.bit_sel] |=> !chk_view[chk_bit_r])
      else $error("bit clear did not store a zero");

   chk_test_reports: assert property (@(posedge clk) disable iff (!rst_b)
      is_test && bit_ok |=> test_valid_r && (test_bit_r == $past(raw_view[req.bit_sel])))
      else $error("bit test answer wrong or missing");

   chk_w1c_clears: assert property (@(posedge clk) disable iff (!rst_b)
      is_wr && in_bank && (dec_idx == lirb_pkg::A_T1_FLAGS) && req.wdata[lirb_pkg::B_TOV1]
      && !per_in.flag_set[lirb_pkg::F_TOV1] |=> !flags_r[lirb_pkg::F_TOV1])
      else $error("flag not cleared by a written one");

   chk_w0_keeps: assert property (@(posedge clk) disable iff (!rst_b)
      is_wr && in_bank && (dec_idx == lirb_pkg::A_T1_FLAGS) && !req.wdata[lirb_pkg::B_TOV1]
      |=> flags_r[lirb_pkg::F_TOV1] == $past(flags_r[lirb_pkg::F_TOV1]))
      else $error("flag changed by a written zero");

   chk_bitop_one_flag: assert property (@(posedge clk) disable iff (!rst_b)
      (is_set || is_clr) |=> $onehot0($past(flags_r) & ~flags_r))
      else $error("bit op cleared more than one flag");

   chk_bitop_range: assert property (@(posedge clk) disable iff (!rst_b)
      (is_set || is_clr) && !bit_ok |-> !wen ##1
      ((flags_r & ~$past(flags_r)) == ($past(per_in.flag_set) & ~$past(flags_r))))
      else $error("bit op outside range took effect");

   chk_alias_read: assert property (@(posedge clk) disable iff (!rst_b)
      is_rd && req.data_space && in_bank |=> rd_valid_r && (rd_data_r == $past(raw_view)))
      else $error("data-space alias read differs");

   cov_set_on_flags: cover property (@(posedge clk) disable iff (!rst_b)
      is_set && bit_ok && (dec_idx == lirb_pkg::A_T1_FLAGS));
   cov_test_set: cover property (@(posedge clk) disable iff (!rst_b)
      is_test && bit_ok ##1 test_bit_r);
   cov_alias_write: cover property (@(posedge clk) disable iff (!rst_b)
      is_wr && req.data_space && in_bank);
endmodule : lirb_bank
`default_nettype wire

/* File: dv/lirb_core_model.sv */
// core-side model: issues one i/o request at a time and collects its answer
`timescale 1ns/1ps
`default_nettype none
module lirb_core_model (
   // clock
   input  wire logic                 clk,
   // request towards the bank
   output var lirb_pkg::lirb_req_t   req,
   // answers from the bank
   input  wire logic [7:0]           rd_data_r,
   input  wire logic                 rd_valid_r,
   input  wire logic                 test_bit_r,
   input  wire logic                 test_valid_r
);

   initial req = '0;

   // raised at one edge, taken at the next; answers are sampled once that edge has settled
   task automatic access(input lirb_pkg::lirb_kind_t kind, input logic ds, input logic [6:0] addr,
                         input logic [2:0] bsel, input logic [7:0] wdata, output logic [7:0] rdata,
                         output logic rvalid, output logic tbit, output logic tvalid);
      lirb_pkg::lirb_req_t r;
      r = '0;
      r.valid = 1'b1;
      r.kind = kind;
      r.data_space = ds;
      r.addr = addr;
      r.bit_sel = bsel;
      r.wdata = wdata;
      // on i/o-address writes, reserved upper nibble of power and port b registers goes out as zero
      if (kind == lirb_pkg::K_WRITE && !ds && (addr == 7'h00 || addr == 7'h17 || addr == 7'h18)) begin
         r.wdata = wdata & 8'h0f;
      end
      // an i/o-address write never reaches the reserved location at 0x11
      if (kind == lirb_pkg::K_WRITE && !ds && addr == 7'h11) begin
         r.valid = 1'b0;
      end
      @(posedge clk);
      req <= r;
      @(posedge clk);
      req <= '0;
      #1;
      rdata = rd_data_r;
      rvalid = rd_valid_r;
      tbit = test_bit_r;
      tvalid = test_valid_r;
   endtask : access

endmodule : lirb_core_model
`default_nettype wire

/* File: dv/lirb_bank_test.sv */
// self-checking bench for the low i/o register bank
`timescale 1ns/1ps
`default_nettype none
module lirb_bank_test;

   logic                      clk;
   logic                      rst_b;
   lirb_pkg::lirb_req_t       req;
   lirb_pkg::lirb_periph_in_t per_in;
   lirb_pkg::lirb_ctrl_t      ctrl;
   logic [7:0]                rd_data_r;
   logic                      rd_valid_r;
   logic                      test_bit_r;
   logic                      test_valid_r;
   int                        bad_count;
   int                        n_tests;
   logic [7:0]                d;
   logic                      v;
   logic                      tb;
   logic                      tv;

   lirb_bank uut (
      .clk          (clk),
      .rst_b        (rst_b),
      .req          (req),
      .rd_data_r    (rd_data_r),
      .rd_valid_r   (rd_valid_r),
      .test_bit_r   (test_bit_r),
      .test_valid_r (test_valid_r),
      .per_in       (per_in),
      .ctrl         (ctrl)
   );

   lirb_core_model core (
      .clk          (clk),
      .req          (req),
      .rd_data_r    (rd_data_r),
      .rd_valid_r   (rd_valid_r),
      .test_bit_r   (test_bit_r),
      .test_valid_r (test_valid_r)
   );

   // 250 mhz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic acc(input lirb_pkg::lirb_kind_t k, input logic ds, input logic [6:0] a,
                      input logic [2:0] b, input logic [7:0] w);
      core.access(k, ds, a, b, w, d, v, tb, tv);
   endtask : acc

   // read answers one cycle later, so the valid pulse is checked along with the data
   task automatic rd(input logic ds, input logic [6:0] a, input logic [7:0] exp);
      acc(lirb_pkg::K_READ, ds, a, 3'h0, 8'h00);
      chk({7'h00, v}, 8'h01, "read answer");
      chk(d, exp, "read data");
   endtask : rd

   task automatic wr(input logic ds, input logic [6:0] a, input logic [7:0] w);
      acc(lirb_pkg::K_WRITE, ds, a, 3'h0, w);
   endtask : wr

   // flag events are one-cycle pulses, like the peripherals give
   task automatic pulse(input logic [lirb_pkg::NFLAG-1:0] f);
      @(posedge clk);
      per_in.flag_set <= f;
      @(posedge clk);
      per_in.flag_set <= '0;
   endtask : pulse

   task automatic end_test(input string name);
      $display("test %s done, mismatches so far %0d", name, bad_count);
   endtask : end_test

   task automatic test_done;
      $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done

   // watchdog: the whole sequence needs well under a thousand cycles
   initial begin
      #(4 * 5000);
      bad_count++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      test_done();
   end

   initial begin
      bad_count = 0;
      n_tests = 0;
      rst_b = 1'b0;
      per_in = '0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;

      // every location starts at zero with all live inputs low
      chk(ctrl.out_b, 8'h00, "reset out_b");
      for (int a = 0; a < 32; a++) begin
         rd(1'b0, 7'(a), 8'h00);
      end
      end_test("reset");

      // byte access through i/o and data-space addresses
      wr(1'b0, 7'h13, 8'ha5);
      rd(1'b1, 7'h33, 8'ha5);
      wr(1'b1, 7'h34, 8'h5a);
      rd(1'b0, 7'h14, 8'h5a);
      per_in.pin_a <= 8'h3c;
      wr(1'b0, 7'h19, 8'hff);
      rd(1'b1, 7'h39, 8'h3c);
      rd(1'b0, 7'h11, 8'h00);
      wr(1'b0, 7'h11, 8'hff);
      rd(1'b0, 7'h11, 8'h00);
      wr(1'b0, 7'h17, 8'hff);
      chk(ctrl.dir_b, 8'h0f, "port b direction");
      per_in.conv_high <= 8'h81;
      per_in.usi_collision <= 1'b1;
      rd(1'b1, 7'h25, 8'h81);
      wr(1'b1, 7'h2e, 8'hff);
      rd(1'b0, 7'h0e, 8'h1f);
      end_test("alias");

      // single-bit set and clear build a byte one bit at a time
      for (int b = 0; b < 8; b++) begin
         acc(lirb_pkg::K_SET, 1'b0, 7'h15, 3'(b), 8'h00);
         rd(1'b0, 7'h15, 8'hff >> (7 - b));
      end
      acc(lirb_pkg::K_CLEAR, 1'b0, 7'h15, 3'h3, 8'h00);
      rd(1'b0, 7'h15, 8'hf7);
      acc(lirb_pkg::K_SET, 1'b0, 7'h18, 3'h2, 8'h00);
      chk(ctrl.out_b, 8'h04, "port b latch");
      end_test("bit ops");

      // bit tests report the live pin level
      per_in.pin_b <= 4'ha;
      for (int b = 0; b < 4; b++) begin
         acc(lirb_pkg::K_TEST, 1'b0, 7'h16, 3'(b), 8'h00);
         chk({6'h00, tv, tb}, {6'h00, 1'b1, 1'(4'ha >> b)}, "bit test");
      end
      end_test("bit test");

      // bit ops through the data-space path or above 0x1f are ignored
      acc(lirb_pkg::K_SET, 1'b1, 7'h33, 3'h1, 8'h00);
      rd(1'b0, 7'h13, 8'ha5);
      acc(lirb_pkg::K_TEST, 1'b1, 7'h36, 3'h1, 8'h00);
      chk({7'h00, tv}, 8'h00, "refused test");
      acc(lirb_pkg::K_TEST, 1'b0, 7'h20, 3'h0, 8'h00);
      chk({7'h00, tv}, 8'h00, "test above range");
      acc(lirb_pkg::K_SET, 1'b0, 7'h33, 3'h1, 8'h00);
      rd(1'b0, 7'h13, 8'ha5);
      end_test("range");

      // timer flags: write one clears, write zero keeps, bit ops touch one flag only
      pulse(9'h007);
      rd(1'b0, 7'h0b, 8'h07);
      wr(1'b0, 7'h0b, 8'h00);
      rd(1'b0, 7'h0b, 8'h07);
      acc(lirb_pkg::K_SET, 1'b0, 7'h0b, 3'h1, 8'h00);
      rd(1'b0, 7'h0b, 8'h05);
      acc(lirb_pkg::K_CLEAR, 1'b0, 7'h0b, 3'h0, 8'h00);
      rd(1'b0, 7'h0b, 8'h05);
      wr(1'b0, 7'h0b, 8'h01);
      rd(1'b0, 7'h0b, 8'h04);
      pulse(9'h008);
      rd(1'b0, 7'h0b, 8'h24);
      chk(ctrl.flags[7:0], 8'h0c, "flag vector");
      end_test("timer flags");

      // a set on a control bit next to a pending comparator flag must keep the flag
      per_in.comp_out <= 1'b1;
      pulse(9'h010);
      rd(1'b0, 7'h08, 8'h30);
      acc(lirb_pkg::K_SET, 1'b0, 7'h08, 3'h0, 8'h00);
      rd(1'b0, 7'h08, 8'h31);
      acc(lirb_pkg::K_SET, 1'b0, 7'h08, 3'h4, 8'h00);
      rd(1'b0, 7'h08, 8'h21);
      end_test("comparator");

      test_done();
   end

endmodule : lirb_bank_test
`default_nettype wire
